// ==== hdl/input_overvoltage_fault_handler.sv ====
/*
 * Input overvoltage fault handler: threshold and reaction registers on a
 * simple command port, comparator, and the fault response sequencer.
 * Assumes measured voltage and exponent come from logic on clk_i, and
 * that the power enable arrives from a pin.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1 - hold programmable linear-format overvoltage threshold
// RL2 - bits 15:11 read back exponent, read-only
// RL3 - bits 10:8 store mantissa high bits
// RL4 - bits 7:0 store mantissa low byte
// RL5 - response field 7:6; code 00 ignores
// RL6 - code 01 rides delay one, then retries
// RL7 - code 10 shuts down at once, retries
// RL8 - code 11 disables until fault clears
// RL9 - retry field 5:3; seven means unlimited
// RL10 - retries exhausted keeps output off latched
// RL11 - latch cleared by reset or enable cycle
// RL12 - delay field sets first delay time
// RL13 - delay field sets restart spacing too
// RL14 - delay tables: 10..1280 ms, 252..2604 ms
// RL15 - fault when measured exceeds threshold
module input_overvoltage_fault_handler #(
    parameter int unsigned cycles_per_ms_p = ovp_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // register command port
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    // measurement inputs
    input  wire logic [2:0]  exponent_i,
    input  wire logic [10:0] input_line_voltage_i,
    // power enable pin
    input  wire logic        power_enable_i,
    // status and control outputs
    output logic             output_enable_o,
    output logic             fault_o,
    output logic             latched_off_o
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [10:0] thresh_r, thresh_nxt;
    logic [7:0]  react_r, react_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [2:0]  en_sync_r, en_sync_nxt;
    logic        en_r, en_nxt;
    logic        fault_r, fault_nxt;
    logic [2:0]  retry_r, retry_nxt;
    logic        out_en_r, out_en_nxt;
    ovp_pkg::ovp_state_t state_r, state_nxt;
    logic        tmr_start;
    logic [11:0] tmr_ms;
    logic        tmr_expired;
    logic [15:0] thresh_word;
    logic [1:0]  resp;
    logic [2:0]  retry_lim;
    logic [2:0]  delay_sel;
    logic        retry_left;

    ////////////////////////////////////////////////////////////////////
    // register fields
    assign resp      = react_r[ovp_pkg::RESP_MSB:ovp_pkg::RESP_LSB];        // RL5
    assign retry_lim = react_r[ovp_pkg::RETRY_MSB:ovp_pkg::RETRY_LSB];      // RL9
    assign delay_sel = react_r[ovp_pkg::DELAY_MSB:ovp_pkg::DELAY_LSB];      // RL12
    // exponent sign-extended from three bits into the read-only field
    assign thresh_word = {{2{exponent_i[2]}}, exponent_i, thresh_r};         // RL2
    assign retry_left  = (retry_lim == ovp_pkg::RETRY_UNLIMITED)
                         || (retry_r < retry_lim);                           // RL9

    ////////////////////////////////////////////////////////////////////
    // register writes and registered read answers
    always_comb begin
        thresh_nxt = thresh_r;
        react_nxt  = react_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = rd_en_i;
        if (wr_en_i && addr_i == ovp_pkg::THRESHOLD_ADDR) begin
            // exponent bits are dropped: they belong to another register
            thresh_nxt[ovp_pkg::MANT_MSB:ovp_pkg::MANT_HI_LSB] =
                wdata_i[ovp_pkg::MANT_MSB:ovp_pkg::MANT_HI_LSB];             // RL3
            thresh_nxt[ovp_pkg::MANT_LO_MSB:0] = wdata_i[ovp_pkg::MANT_LO_MSB:0]; // RL4
        end
        if (wr_en_i && addr_i == ovp_pkg::REACTION_ADDR) begin
            react_nxt = wdata_i[7:0];
        end
        if (rd_en_i) begin
            unique case (addr_i)
                ovp_pkg::THRESHOLD_ADDR: rdata_nxt = thresh_word;              // RL1
                ovp_pkg::REACTION_ADDR:  rdata_nxt = {8'h00, react_r};
                default:                 rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thresh_r <= ovp_pkg::THRESHOLD_RESET;
            react_r  <= ovp_pkg::REACTION_RESET;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            thresh_r <= thresh_nxt;
            react_r  <= react_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // enable pin sync and comparator; same exponent on both sides, so
    // mantissas compare directly
    always_comb begin
        en_sync_nxt = {en_sync_r[1:0], power_enable_i};
        en_nxt      = (en_sync_r[2] == en_sync_r[1]) ? en_sync_r[2] : en_r;
        fault_nxt   = input_line_voltage_i > thresh_r;                      // RL15
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_sync_r <= 3'h0;
            en_r      <= 1'b0;
            fault_r   <= 1'b0;
        end else begin
            en_sync_r <= en_sync_nxt;
            en_r      <= en_nxt;
            fault_r   <= fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // response sequencer
    always_comb begin
        state_nxt  = state_r;
        retry_nxt  = retry_r;
        out_en_nxt = out_en_r;
        tmr_start  = 1'b0;
        tmr_ms     = ovp_pkg::FIRST_DELAY_MS[delay_sel];                    // RL14
        if (!en_r) begin
            // enable low ends any latch and clears the retry history
            state_nxt  = ovp_pkg::ST_IDLE;                                  // RL11
            retry_nxt  = 3'h0;
            out_en_nxt = 1'b0;
        end else begin
            unique case (state_r)
                ovp_pkg::ST_IDLE: begin
                    state_nxt  = ovp_pkg::ST_RUN;
                    out_en_nxt = 1'b1;
                end
                ovp_pkg::ST_RUN: begin
                    if (fault_r) begin
                        unique case (resp)
                            ovp_pkg::RESP_IGNORE: state_nxt = ovp_pkg::ST_RUN; // RL5
                            ovp_pkg::RESP_RIDE: begin
                                state_nxt = ovp_pkg::ST_RIDE;               // RL6
                                tmr_start = 1'b1;                           // RL12
                            end
                            ovp_pkg::RESP_SHUTDOWN: begin
                                out_en_nxt = 1'b0;                          // RL7
                                tmr_start  = 1'b1;
                                tmr_ms     = ovp_pkg::RESTART_GAP_MS[delay_sel]; // RL13
                                state_nxt  = retry_left ? ovp_pkg::ST_OFF_WAIT
                                                        : ovp_pkg::ST_LATCHED;
                            end
                            ovp_pkg::RESP_WAIT_CLEAR: begin
                                out_en_nxt = 1'b0;                          // RL8
                                state_nxt  = ovp_pkg::ST_WAIT_CLEAR;
                            end
                        endcase
                    end
                end
                ovp_pkg::ST_RIDE: begin
                    // output stays on while riding through
                    if (!fault_r) begin
                        state_nxt = ovp_pkg::ST_RUN;
                    end else if (tmr_expired) begin
                        out_en_nxt = 1'b0;                                  // RL6
                        tmr_start  = 1'b1;
                        tmr_ms     = ovp_pkg::RESTART_GAP_MS[delay_sel];    // RL13
                        state_nxt  = retry_left ? ovp_pkg::ST_OFF_WAIT
                                                : ovp_pkg::ST_LATCHED;      // RL10
                    end
                end
                ovp_pkg::ST_OFF_WAIT: begin
                    if (tmr_expired) begin
                        // unlimited mode does not count, so it never wraps
                        if (retry_lim != ovp_pkg::RETRY_UNLIMITED) begin
                            retry_nxt = retry_r + 3'h1;                     // RL9
                        end
                        out_en_nxt = 1'b1;
                        tmr_start  = 1'b1;
                        state_nxt  = ovp_pkg::ST_RESTART;
                    end
                end
                ovp_pkg::ST_RESTART: begin
                    // a restart counts as good after one first-delay window
                    if (fault_r) begin
                        out_en_nxt = 1'b0;
                        tmr_start  = 1'b1;
                        tmr_ms     = ovp_pkg::RESTART_GAP_MS[delay_sel];    // RL13
                        state_nxt  = retry_left ? ovp_pkg::ST_OFF_WAIT
                                                : ovp_pkg::ST_LATCHED;      // RL10
                    end else if (tmr_expired) begin
                        retry_nxt = 3'h0;
                        state_nxt = ovp_pkg::ST_RUN;
                    end
                end
                ovp_pkg::ST_WAIT_CLEAR: begin
                    if (!fault_r) begin
                        out_en_nxt = 1'b1;                                  // RL8
                        state_nxt  = ovp_pkg::ST_RUN;
                    end
                end
                ovp_pkg::ST_LATCHED: begin
                    out_en_nxt = 1'b0;                                      // RL10
                end
                default: begin
                    state_nxt  = ovp_pkg::ST_IDLE;
                    out_en_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r  <= ovp_pkg::ST_IDLE;                                   // RL11
            retry_r  <= 3'h0;
            out_en_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            retry_r  <= retry_nxt;
            out_en_r <= out_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared delay timer
    ms_timer #(
        .tick_cycles_p (cycles_per_ms_p)
    ) u_timer (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (tmr_start),
        .ms_i      (tmr_ms),
        .expired_o (tmr_expired)
    );

    // outputs
    assign rdata_o         = rdata_r;
    assign rvalid_o        = rvalid_r;
    assign output_enable_o = out_en_r;
    assign fault_o         = fault_r;
    assign latched_off_o   = (state_r == ovp_pkg::ST_LATCHED);

endmodule

`default_nettype wire

// ==== hdl/ms_timer.sv ====
/*
 * Millisecond down-timer: a start pulse loads a count of ms, expired_o
 * rises after that many ms and stays until the next start.
 * Assumes tick_cycles_p equals clock cycles per ms.
 */
`timescale 1ns/1ps
`default_nettype none

module ms_timer #(
    parameter int unsigned tick_cycles_p = 25000
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // control
    input  wire logic        start_i,
    input  wire logic [11:0] ms_i,
    // status
    output logic             expired_o
);

    logic [31:0] pre_r, pre_nxt;
    logic [11:0] remain_r, remain_nxt;
    logic        run_r, run_nxt;
    logic        exp_r, exp_nxt;

    ////////////////////////////////////////////////////////////////////
    // prescaler and ms countdown; a restart wins over a running count
    always_comb begin
        pre_nxt    = pre_r;
        remain_nxt = remain_r;
        run_nxt    = run_r;
        exp_nxt    = exp_r;
        if (start_i) begin
            pre_nxt    = 32'h0000_0000;
            remain_nxt = ms_i;
            run_nxt    = 1'b1;
            exp_nxt    = 1'b0;
        end else if (run_r) begin
            if (pre_r == 32'(tick_cycles_p - 1)) begin
                pre_nxt = 32'h0000_0000;
                if (remain_r <= 12'h001) begin
                    run_nxt = 1'b0;
                    exp_nxt = 1'b1;
                end else begin
                    remain_nxt = remain_r - 12'h001;
                end
            end else begin
                pre_nxt = pre_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_r    <= 32'h0000_0000;
            remain_r <= 12'h000;
            run_r    <= 1'b0;
            exp_r    <= 1'b0;
        end else begin
            pre_r    <= pre_nxt;
            remain_r <= remain_nxt;
            run_r    <= run_nxt;
            exp_r    <= exp_nxt;
        end
    end

    assign expired_o = exp_r;

endmodule

`default_nettype wire

// ==== hdl/ovp_pkg.sv ====
/*
 * Package for the input overvoltage fault handler: register offsets,
 * field positions, reset values, delay tables and timing counts.
 * Assumes a single 25 MHz system clock.
 */
package ovp_pkg;

    // register command codes
    localparam logic [7:0]  THRESHOLD_ADDR   = 8'h55;
    localparam logic [7:0]  REACTION_ADDR    = 8'h56;

    // threshold field layout
    localparam int          EXP_MSB          = 15;
    localparam int          EXP_LSB          = 11;
    localparam int          MANT_MSB         = 10;
    localparam int          MANT_HI_LSB      = 8;
    localparam int          MANT_LO_MSB      = 7;

    // reaction field layout
    localparam int          RESP_MSB         = 7;
    localparam int          RESP_LSB         = 6;
    localparam int          RETRY_MSB        = 5;
    localparam int          RETRY_LSB        = 3;
    localparam int          DELAY_MSB        = 2;
    localparam int          DELAY_LSB        = 0;

    // reset values
    localparam logic [10:0] THRESHOLD_RESET  = 11'h7FF;
    localparam logic [7:0]  REACTION_RESET   = 8'h00;

    // response codes
    localparam logic [1:0]  RESP_IGNORE      = 2'h0;
    localparam logic [1:0]  RESP_RIDE        = 2'h1;
    localparam logic [1:0]  RESP_SHUTDOWN    = 2'h2;
    localparam logic [1:0]  RESP_WAIT_CLEAR  = 2'h3;
    localparam logic [2:0]  RETRY_UNLIMITED  = 3'h7;

    // timing
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          CYCLES_PER_MS    = CLK_HZ / 1000;

    // delay tables in ms, indexed by the delay field
    localparam logic [11:0] FIRST_DELAY_MS [8] = '{
        12'h00A, 12'h014, 12'h028, 12'h050, 12'h0A0, 12'h140, 12'h280, 12'h500};
    localparam logic [11:0] RESTART_GAP_MS [8] = '{
        12'h0FC, 12'h22E, 12'h39C, 12'h4EC, 12'h63C, 12'h78C, 12'h8DC, 12'hA2C};

    // handler states
    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_RIDE, ST_OFF_WAIT, ST_RESTART, ST_WAIT_CLEAR, ST_LATCHED
    } ovp_state_t;

endpackage

// ==== verif/ovp_host.sv ====
/*
 * Management host model: single-cycle register writes and reads.
 * Assumes the handler answers a read one cycle after taking it.
 */
`timescale 1ns/1ps
`default_nettype none

module ovp_host (
    // clock
    input  wire logic        clk_i,
    // command side
    output logic             wr_en_o,
    output logic             rd_en_o,
    output logic [7:0]       addr_o,
    output logic [15:0]      wdata_o,
    // answer side
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i
);

    // idle bus at time zero
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // released lines show inverted data so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        ok = rvalid_i;
        d = rdata_i;
        rd_en_o = 1'b0;
        addr_o = ~a;
    endtask

endmodule

`default_nettype wire

// ==== verif/ovp_monitor.sv ====
/*
 * Port checker for the input overvoltage fault handler.
 * Assumes it is bound to the handler top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module ovp_monitor #(
    parameter int unsigned cycles_per_ms_p = 4
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] rdata_o,
    input  wire logic        rvalid_o,
    // measurement and control
    input  wire logic [2:0]  exponent_i,
    input  wire logic [10:0] input_line_voltage_i,
    input  wire logic        power_enable_i,
    input  wire logic        output_enable_o,
    input  wire logic        fault_o,
    input  wire logic        latched_off_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////
    // register answers
    chk_read_answer: assert property (rd_en_i |=> rvalid_o)
        else $error("read got no answer");
    chk_no_stray: assert property (!rd_en_i |=> !rvalid_o)
        else $error("answer without a read");
    chk_exp_readback: assert property (
        rd_en_i && addr_i == ovp_pkg::THRESHOLD_ADDR |=>
        rdata_o[15:11] == {{2{$past(exponent_i[2])}}, $past(exponent_i)})
        else $error("threshold exponent field wrong");
    chk_react_upper: assert property (
        rd_en_i && addr_i == ovp_pkg::REACTION_ADDR |=> rdata_o[15:8] == 8'h00)
        else $error("reaction upper byte not zero");
    chk_unmapped_zero: assert property (
        rd_en_i && addr_i != ovp_pkg::THRESHOLD_ADDR
        && addr_i != ovp_pkg::REACTION_ADDR |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    ////////////////////////////////////////////////////////////////////////
    // fault sequencing; sync depth is not exact, so bounds are generous
    chk_zero_no_fault: assert property (
        $past(input_line_voltage_i) == 11'h000 |-> !fault_o)
        else $error("fault with zero input");
    chk_fall_cause: assert property (
        $fell(output_enable_o) |-> $past(fault_o) || !power_enable_i)
        else $error("output dropped without cause");
    chk_latch_off: assert property (latched_off_o |-> !output_enable_o)
        else $error("output on while latched");
    chk_enable_low: assert property (
        !power_enable_i [*8] |=> !output_enable_o && !latched_off_o)
        else $error("enable low did not clear");
    chk_rise_guard: assert property (
        $rose(output_enable_o) |-> $past(power_enable_i, 3))
        else $error("output rose without enable");

endmodule

bind input_overvoltage_fault_handler ovp_monitor #(
    .cycles_per_ms_p(cycles_per_ms_p)
) u_mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .exponent_i(exponent_i),
    .input_line_voltage_i(input_line_voltage_i), .power_enable_i(power_enable_i),
    .output_enable_o(output_enable_o), .fault_o(fault_o), .latched_off_o(latched_off_o)
);

`default_nettype wire

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the overvoltage handler, 4 cycles per ms.
 * Assumes the host model and the bound checker compile alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [2:0]  expo;
        logic [15:0] rexp;
    } row_t;

    logic        clk_i;
    logic        rst_n_i = 1'b0;
    logic        wr_en_i, rd_en_i, rvalid_o, fault_o, latched_off_o, output_enable_o;
    logic [7:0]  addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic [2:0]  exponent_i = 3'h0;
    logic [10:0] input_line_voltage_i = 11'h000;
    logic        power_enable_i = 1'b1;
    int          miscompares = 0;
    int          checks = 0;
    int          n;
    // write rows: mantissa kept, exponent sign-extended, unmapped reads zero
    row_t        rows [4] = '{
        '{8'h55, 16'hFABC, 3'h5, 16'hEABC}, '{8'h55, 16'h0005, 3'h2, 16'h1005},
        '{8'h56, 16'hFFC5, 3'h0, 16'h00C5}, '{8'h57, 16'h1234, 3'h0, 16'h0000}};

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    input_overvoltage_fault_handler #(.cycles_per_ms_p(4)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .exponent_i(exponent_i), .input_line_voltage_i(input_line_voltage_i),
        .power_enable_i(power_enable_i), .output_enable_o(output_enable_o),
        .fault_o(fault_o), .latched_off_o(latched_off_o));

    ovp_host u_host (
        .clk_i(clk_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
        .wdata_o(wdata_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o));

    ////////////////////////////////////////////////////////////////////////
    // compares and helpers
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_time(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        u_host.rd(a, d, ok);
        chk_val({15'h0000, ok}, 16'h0001);
        chk_val(d, exp);
    endtask

    // bounded wait on the output enable, counted in cycles
    task automatic wait_oe(input logic v, input int lim, output int c);
        c = 0;
        while (output_enable_o !== v && c < lim) begin
            @(negedge clk_i);
            c++;
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        rd_chk(ovp_pkg::THRESHOLD_ADDR, {5'h00, ovp_pkg::THRESHOLD_RESET});
        rd_chk(ovp_pkg::REACTION_ADDR, {8'h00, ovp_pkg::REACTION_RESET});
        foreach (rows[i]) begin
            exponent_i = rows[i].expo;
            u_host.wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rexp);
        end
        // strict compare at the boundary, code 00 ignores
        exponent_i = 3'h0;
        u_host.wr(ovp_pkg::REACTION_ADDR, 16'h0000);
        u_host.wr(ovp_pkg::THRESHOLD_ADDR, 16'h0100);
        input_line_voltage_i = 11'h100;
        // let the registered comparator see the new level before looking
        repeat (3) @(negedge clk_i);
        chk_val({15'h0000, fault_o}, 16'h0000);
        input_line_voltage_i = 11'h101;
        repeat (50) @(negedge clk_i);
        chk_val({15'h0000, fault_o}, 16'h0001);
        chk_val({15'h0000, output_enable_o}, 16'h0001);
        // code 11: off while present, back on when cleared
        u_host.wr(ovp_pkg::REACTION_ADDR, 16'h00C0);
        wait_oe(1'b0, 10, n);
        chk_time(n, 0, 4);
        input_line_voltage_i = 11'h000;
        wait_oe(1'b1, 10, n);
        chk_time(n, 1, 4);
        // code 10, one retry, shortest delays
        u_host.wr(ovp_pkg::REACTION_ADDR, 16'h0088);
        input_line_voltage_i = 11'h101;
        wait_oe(1'b0, 10, n);
        chk_time(n, 1, 3);
        wait_oe(1'b1, 1100, n);
        chk_time(n, 1000, 1012);
        wait_oe(1'b0, 5, n);
        chk_time(n, 1, 3);
        input_line_voltage_i = 11'h000;
        repeat (50) @(negedge clk_i);
        chk_val({14'h0000, latched_off_o, output_enable_o}, 16'h0002);
        power_enable_i = 1'b0;
        repeat (10) @(negedge clk_i);
        chk_val({15'h0000, latched_off_o}, 16'h0000);
        power_enable_i = 1'b1;
        wait_oe(1'b1, 20, n);
        chk_time(n, 5, 19);
        // code 01, no retries, delay code 1: short fault rides through
        u_host.wr(ovp_pkg::REACTION_ADDR, 16'h0041);
        input_line_voltage_i = 11'h101;
        repeat (40) @(negedge clk_i);
        chk_val({15'h0000, output_enable_o}, 16'h0001);
        input_line_voltage_i = 11'h000;
        repeat (5) @(negedge clk_i);
        input_line_voltage_i = 11'h101;
        wait_oe(1'b0, 200, n);
        chk_time(n, 76, 88);
        repeat (4) @(negedge clk_i);
        chk_val({15'h0000, latched_off_o}, 16'h0001);
        // reset in mid-run clears the latch and the registers
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk_val({14'h0000, latched_off_o, output_enable_o}, 16'h0000);
        rst_n_i = 1'b1;
        rd_chk(ovp_pkg::REACTION_ADDR, {8'h00, ovp_pkg::REACTION_RESET});
        // code 10, unlimited retries: eight failed restarts never latch
        u_host.wr(ovp_pkg::THRESHOLD_ADDR, 16'h0100);
        u_host.wr(ovp_pkg::REACTION_ADDR, 16'h00B8);
        wait_oe(1'b0, 10, n);
        chk_time(n, 1, 3);
        repeat (8) begin
            wait_oe(1'b1, 1100, n);
            chk_time(n, 1000, 1012);
            wait_oe(1'b0, 5, n);
            chk_time(n, 1, 3);
        end
        chk_val({15'h0000, latched_off_o}, 16'h0000);
        conclude();
    end

    // whole run needs about 9500 cycles, mostly restart gaps
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        conclude();
    end

endmodule

`default_nettype wire
